// ==== logic/pmpm_master_port.sv ====
// Operation
// - Set strobe or address pin enable gives pin to port; clear returns it to I/O.
// - Enabled address pins drive matching address register bits; disabled pins are released.
// - Enabled chip select pins sit inactive whenever no transfer runs.
// - Address pin 0 and 1 enables also gate the low and high latch strobes.
// - Mode 1 drives direction plus enable line; mode 2 drives separate read, write strobes.
// - Every control output follows its polarity bit; latches share one, shared pins share one.
// - Step field 00 keeps, 01 increments, 10 decrements address by one after each transfer.
// - Address bits used as chip selects never take part in stepping.
// - One wait state equals one peripheral clock cycle.
// - Strobe wait zero means one-cycle strobe and setup, setup and hold fields ignored.
// - With strobe wait zero, hold is one cycle for writes, zero for reads.
// - Setup wait field sets data setup cycles before the active strobe.
// - In multiplexed modes setup wait lengthens the address period instead.
// - Strobe wait field sets how long the active strobe stays asserted.
// - Hold wait field sets data hold cycles after the active strobe.
// - Multiplex field picks separate, low-byte, full 8-pin or full 16-pin addressing.
// - Demultiplexed: address on address pins, data on 16 or 8 data pins.
// - Partial: low address byte on data 7:0 with low latch; at least 3 extra cycles.
// - Nonzero strobe wait lengthens each latch strobe by the setup wait count.
// - Full 8-pin: low byte with low latch, then high byte with high latch; at least 6 extra.
// - Full multiplexing forces address bits 15 and 14 to zero for enabled chip selects.
// - Full 16-pin: both latches together, low byte 7:0, high byte 15:8.
// - Chip select function 10 enables both chip selects instead of address 15 and 14.
// - Function 00 keeps both as address, 01 enables only the upper chip select.
module pmpm_master_port
   import pmpm_pkg::*;
#(
   parameter int BUF_DEPTH = 2
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Configuration
   input  wire pmpm_cfg_s   cfg_i,
   // Address register access
   input  wire logic        addr_load_i,
   input  wire logic [15:0] addr_load_data_i,
   output logic      [15:0] address_register_o,
   output logic             busy_o,
   // Transfer requests
   input  wire logic        req_valid_i,
   output logic             req_ready_o,
   input  wire pmpm_req_s   req_i,
   // Read data
   output logic             rd_valid_o,
   input  wire logic        rd_ready_i,
   output logic      [15:0] rd_data_o,
   // Parallel pins
   output logic      [15:0] address_pins_o,
   output logic      [15:0] address_pins_oe_o,
   input  wire logic [15:0] data_pins_i,
   output logic      [15:0] data_pins_o,
   output logic      [15:0] data_pins_oe_o,
   output logic             read_strobe_o,
   output logic             read_strobe_oe_o,
   output logic             write_strobe_o,
   output logic             write_strobe_oe_o
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Active level to pin level; 1 selects active high
   function automatic logic pin_level(input logic active, input logic pol);
      return pol ? active : ~active;
   endfunction

   localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   pmpm_state_e state_q, state_d;
   logic [3:0]  cnt_q, cnt_d;
   logic        wr_q, wr_d;
   logic [15:0] wdata_q, wdata_d;
   logic [15:0] addr_q, addr_d;
   logic [15:0] cap_q, cap_d;
   logic [15:0] sync1_q, sync2_q;
   logic        busy_q, busy_d;
   logic        ready_q, ready_d;
   logic [15:0] mem_q [BUF_DEPTH];
   logic [15:0] mem_d [BUF_DEPTH];
   logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [PW:0] cnt_buf_q, cnt_buf_d;
   logic        rvalid_q, rvalid_d;
   logic [15:0] rdata_q, rdata_d;
   logic        finish, accept, pop, push;
   logic        muxed, strobe_wait_count_zero;
   logic [3:0]  setup_m1, latch_m1, hold_len;
   logic [15:0] step_keep, stepped;

   // Phase lengths, loaded as length minus one into the counter
   always_comb begin
      muxed      = cfg_i.address_multiplex_select != MUX_NONE;
      strobe_wait_count_zero = cfg_i.strobe_wait_count == STROBE_WAIT_COUNT_NONE;
      // Setup moves to the address period when multiplexed
      setup_m1   = (strobe_wait_count_zero || muxed) ? 4'h0 : {2'h0, cfg_i.setup_wait_count};
      latch_m1   = strobe_wait_count_zero ? 4'h0 : {2'h0, cfg_i.setup_wait_count};
      if (strobe_wait_count_zero) begin
         hold_len = wr_q ? DEF_WR_HOLD : DEF_RD_HOLD;
      end else begin
         hold_len = {2'h0, cfg_i.hold_wait_count};
      end
   end

   // Chip select bits stay out of stepping
   always_comb begin
      step_keep = 16'h0000;
      if (cfg_i.chip_select_function != CSF_NONE) begin
         step_keep[CS_HIGH_PIN] = 1'b1;
      end
      if (cfg_i.chip_select_function == CSF_BOTH) begin
         step_keep[CS_LOW_PIN] = 1'b1;
      end
      case (cfg_i.address_step_select)
         STEP_INC: stepped = addr_q + 16'h0001;
         STEP_DEC: stepped = addr_q - 16'h0001;
         default:  stepped = addr_q;
      endcase
      stepped = (addr_q & step_keep) | (stepped & ~step_keep);
   end

   // ----------------------------------------------------------------
   // Transfer sequencer
   // ----------------------------------------------------------------
   // Requests are taken only while idle, so a busy port ignores nothing silently
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q - 4'h1;
      wr_d    = wr_q;
      wdata_d = wdata_q;
      cap_d   = cap_q;
      finish  = 1'b0;
      accept  = req_valid_i && ready_q;
      case (state_q)
         ST_IDLE: begin
            cnt_d = 4'h0;
            if (accept) begin
               wr_d    = req_i.write;
               wdata_d = req_i.data;
               if (muxed) begin
                  state_d = ST_LAT_LO;
                  cnt_d   = latch_m1;
               end else begin
                  state_d = ST_SETUP;
                  cnt_d   = setup_m1;
               end
            end
         end
         ST_LAT_LO: begin
            if (cnt_q == 4'h0) begin
               state_d = ST_GAP_LO;
               cnt_d   = ADDR_GAP_CYCLES - 4'h1;
            end
         end
         ST_GAP_LO: begin
            if (cnt_q == 4'h0) begin
               // Second address byte only on the 8-pin full mode
               if (cfg_i.address_multiplex_select == MUX_FULL8) begin
                  state_d = ST_LAT_HI;
                  cnt_d   = latch_m1;
               end else begin
                  state_d = ST_SETUP;
                  cnt_d   = setup_m1;
               end
            end
         end
         ST_LAT_HI: begin
            if (cnt_q == 4'h0) begin
               state_d = ST_GAP_HI;
               cnt_d   = ADDR_GAP_CYCLES - 4'h1;
            end
         end
         ST_GAP_HI: begin
            if (cnt_q == 4'h0) begin
               state_d = ST_SETUP;
               cnt_d   = setup_m1;
            end
         end
         ST_SETUP: begin
            if (cnt_q == 4'h0) begin
               state_d = ST_STROBE;
               cnt_d   = cfg_i.strobe_wait_count;
            end
         end
         ST_STROBE: begin
            if (cnt_q == 4'h0) begin
               if (!wr_q) begin
                  cap_d = cfg_i.wide_data_select ? sync2_q : {8'h00, sync2_q[7:0]};
               end
               if (hold_len != 4'h0) begin
                  state_d = ST_HOLD;
                  cnt_d   = hold_len - 4'h1;
               end else begin
                  state_d = ST_IDLE;
                  finish  = 1'b1;
               end
            end
         end
         ST_HOLD: begin
            if (cnt_q == 4'h0) begin
               state_d = ST_IDLE;
               finish  = 1'b1;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      // Address steps when the transfer completes
      addr_d = addr_q;
      if (finish) begin
         addr_d = stepped;
      end else if (addr_load_i && state_q == ST_IDLE) begin
         addr_d = addr_load_data_i;
      end
      busy_d = state_d != ST_IDLE;
   end

   // Sequencer registers; data pins pass two stages before use
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         cnt_q   <= 4'h0;
         wr_q    <= 1'b0;
         wdata_q <= 16'h0000;
         addr_q  <= ADDR_RESET;
         cap_q   <= 16'h0000;
         busy_q  <= 1'b0;
         sync1_q <= 16'h0000;
         sync2_q <= 16'h0000;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         wr_q    <= wr_d;
         wdata_q <= wdata_d;
         addr_q  <= addr_d;
         cap_q   <= cap_d;
         busy_q  <= busy_d;
         sync1_q <= data_pins_i;
         sync2_q <= sync1_q;
      end
   end

   // ----------------------------------------------------------------
   // Read data buffer
   // ----------------------------------------------------------------
   // A full buffer holds off new requests, so a stalled reader never loses a word
   always_comb begin
      mem_d = mem_q;
      wp_d  = wp_q;
      rp_d  = rp_q;
      push  = finish && !wr_q;
      pop   = rvalid_q && rd_ready_i;
      if (push) begin
         mem_d[wp_q] = cap_d;
         wp_d        = (wp_q == PW'(BUF_DEPTH - 1)) ? '0 : wp_q + PW'(1);
      end
      if (pop) begin
         rp_d = (rp_q == PW'(BUF_DEPTH - 1)) ? '0 : rp_q + PW'(1);
      end
      cnt_buf_d = cnt_buf_q + (PW+1)'(push) - (PW+1)'(pop);
      rvalid_d  = cnt_buf_d != '0;
      rdata_d   = mem_d[rp_d];
      ready_d   = cfg_i.port_enable && state_d == ST_IDLE && !addr_load_i
                  && cnt_buf_d < (PW+1)'(BUF_DEPTH);
   end

   // Buffer registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < BUF_DEPTH; i++) begin
            mem_q[i] <= 16'h0000;
         end
         wp_q      <= '0;
         rp_q      <= '0;
         cnt_buf_q <= '0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 16'h0000;
         ready_q   <= 1'b0;
      end else begin
         mem_q     <= mem_d;
         wp_q      <= wp_d;
         rp_q      <= rp_d;
         cnt_buf_q <= cnt_buf_d;
         rvalid_q  <= rvalid_d;
         rdata_q   <= rdata_d;
         ready_q   <= ready_d;
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   logic        xfer, strobe_act, lat_lo, lat_hi, addr_ph, hi_ph, data_ph;
   logic [15:0] abus, apin_d, apin_q, aoe_q, dout_d, dout_q, doe_d, doe_q;
   logic        rd_d, rdp_q, wrp_d, wrp_q, rdoe_q, wroe_q;

   always_comb begin
      xfer       = state_q != ST_IDLE;
      strobe_act = state_q == ST_STROBE;
      addr_ph    = state_q inside {ST_LAT_LO, ST_GAP_LO, ST_LAT_HI, ST_GAP_HI};
      hi_ph      = state_q inside {ST_LAT_HI, ST_GAP_HI};
      data_ph    = state_q inside {ST_SETUP, ST_STROBE, ST_HOLD};
      // Both latches together in the 16-pin mode
      lat_lo     = state_q == ST_LAT_LO;
      lat_hi     = (state_q == ST_LAT_HI)
                   || (lat_lo && cfg_i.address_multiplex_select == MUX_FULL16);
      // Chip select bits read as zero on a full multiplexed bus
      abus = addr_q;
      if (cfg_i.address_multiplex_select inside {MUX_FULL8, MUX_FULL16}) begin
         abus = addr_q & ~step_keep;
      end
      // Address pins, some taken over by latches and chip selects
      apin_d = addr_q;
      if (muxed) begin
         apin_d[LATCH_LO_PIN] = pin_level(lat_lo, cfg_i.latch_strobe_polarity);
      end
      if (cfg_i.address_multiplex_select inside {MUX_FULL8, MUX_FULL16}) begin
         apin_d[LATCH_HI_PIN] = pin_level(lat_hi, cfg_i.latch_strobe_polarity);
      end
      if (cfg_i.chip_select_function != CSF_NONE) begin
         apin_d[CS_HIGH_PIN] = pin_level(xfer, cfg_i.chip_select_high_polarity);
      end
      if (cfg_i.chip_select_function == CSF_BOTH) begin
         apin_d[CS_LOW_PIN] = pin_level(xfer, cfg_i.chip_select_low_polarity);
      end
      apin_d = apin_d & cfg_i.address_pin_enable;
      // Data pins carry address bytes in address phases, then write data
      dout_d = cfg_i.wide_data_select ? wdata_q : {8'h00, wdata_q[7:0]};
      doe_d  = 16'h0000;
      if (wr_q && data_ph) begin
         doe_d = cfg_i.wide_data_select ? 16'hFFFF : 16'h00FF;
      end
      if (addr_ph) begin
         if (cfg_i.address_multiplex_select == MUX_FULL16) begin
            dout_d = abus;
            doe_d  = 16'hFFFF;
         end else begin
            dout_d[7:0] = hi_ph ? abus[15:8] : abus[7:0];
            doe_d[7:0]  = 8'hFF;
         end
      end
      // Strobe styles per master mode
      if (cfg_i.master_mode1) begin
         rd_d  = pin_level(xfer && !wr_q, cfg_i.read_strobe_polarity);
         wrp_d = pin_level(strobe_act, cfg_i.write_strobe_polarity);
      end else begin
         rd_d  = pin_level(strobe_act && !wr_q, cfg_i.read_strobe_polarity);
         wrp_d = pin_level(strobe_act && wr_q, cfg_i.write_strobe_polarity);
      end
      rd_d  = rd_d && cfg_i.read_strobe_pin_enable;
      wrp_d = wrp_d && cfg_i.write_strobe_pin_enable;
   end

   // Pin registers; every pin changes one cycle after the sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         apin_q <= 16'h0000;
         aoe_q  <= 16'h0000;
         dout_q <= 16'h0000;
         doe_q  <= 16'h0000;
         rdp_q  <= 1'b0;
         wrp_q  <= 1'b0;
         rdoe_q <= 1'b0;
         wroe_q <= 1'b0;
      end else begin
         apin_q <= apin_d;
         aoe_q  <= cfg_i.address_pin_enable;
         dout_q <= dout_d;
         doe_q  <= doe_d;
         rdp_q  <= rd_d;
         wrp_q  <= wrp_d;
         rdoe_q <= cfg_i.read_strobe_pin_enable;
         wroe_q <= cfg_i.write_strobe_pin_enable;
      end
   end

   assign address_pins_o     = apin_q;
   assign address_pins_oe_o  = aoe_q;
   assign data_pins_o        = dout_q;
   assign data_pins_oe_o     = doe_q;
   assign read_strobe_o      = rdp_q;
   assign read_strobe_oe_o   = rdoe_q;
   assign write_strobe_o     = wrp_q;
   assign write_strobe_oe_o  = wroe_q;
   assign address_register_o = addr_q;
   assign busy_o             = busy_q;
   assign req_ready_o        = ready_q;
   assign rd_valid_o         = rvalid_q;
   assign rd_data_o          = rdata_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_pin_ownership: assert property (1'b1 |=> address_pins_oe_o == $past(cfg_i.address_pin_enable)
                                     && read_strobe_oe_o == $past(cfg_i.read_strobe_pin_enable))
      else $error("pin ownership does not follow enables");
   a_addr_drive: assert property (state_q == ST_IDLE && !muxed && cfg_i.address_pin_enable[5]
                                  |=> address_pins_o[5] == $past(addr_q[5]))
      else $error("address pin does not show address bit");
   a_cs_idle_level: assert property (state_q == ST_IDLE && cfg_i.chip_select_function != CSF_NONE
                                     && cfg_i.address_pin_enable[CS_HIGH_PIN]
                                     |=> address_pins_o[CS_HIGH_PIN] == !$past(cfg_i.chip_select_high_polarity))
      else $error("chip select not inactive while idle");
   a_step_inc: assert property (finish && cfg_i.address_step_select == STEP_INC
                                |=> addr_q[13:0] == $past(addr_q[13:0]) + 14'h0001)
      else $error("address did not increment");
   a_step_cs_keep: assert property (finish && cfg_i.chip_select_function == CSF_BOTH
                                    |=> addr_q[15:14] == $past(addr_q[15:14]))
      else $error("chip select bits stepped");
   a_strobe_length: assert property ($rose(state_q == ST_STROBE) && cfg_i.strobe_wait_count == 4'h2
                                     && $stable(cfg_i) |-> (state_q == ST_STROBE)[*3] ##1 state_q != ST_STROBE)
      else $error("strobe length wrong");
   a_zero_wait_setup: assert property ($rose(state_q == ST_SETUP) && strobe_wait_count_zero |=> state_q == ST_STROBE)
      else $error("setup not one cycle");
   a_read_hold_zero: assert property (state_q == ST_STROBE && cnt_q == 4'h0 && strobe_wait_count_zero && !wr_q
                                      |=> state_q == ST_IDLE)
      else $error("read hold not zero");
   a_write_hold_one: assert property (state_q == ST_STROBE && cnt_q == 4'h0 && strobe_wait_count_zero && wr_q
                                      |=> state_q == ST_HOLD ##1 state_q == ST_IDLE)
      else $error("write hold not one");
   a_latch_low: assert property (state_q == ST_LAT_LO && cfg_i.address_pin_enable[LATCH_LO_PIN]
                                 |=> address_pins_o[LATCH_LO_PIN] == $past(cfg_i.latch_strobe_polarity)
                                     && data_pins_oe_o[7:0] == 8'hFF)
      else $error("low latch strobe wrong");
   a_mode2_write: assert property (state_q == ST_STROBE && wr_q && !cfg_i.master_mode1
                                   && cfg_i.write_strobe_pin_enable
                                   |=> write_strobe_o == $past(cfg_i.write_strobe_polarity))
      else $error("write strobe not active");

   c_write_demux: cover property (state_q == ST_HOLD && wr_q && !muxed ##1 state_q == ST_IDLE);
   c_read_full8: cover property (state_q == ST_LAT_HI ##[1:40] push);
   c_buffer_full: cover property (cnt_buf_q == (PW+1)'(BUF_DEPTH) && req_valid_i);

endmodule

// ==== logic/pmpm_pkg.sv ====
package pmpm_pkg;

   // ----------------------------------------------------------------
   // Widths and timing
   // ----------------------------------------------------------------
   localparam int ADDR_W          = 16;
   localparam int DATA_W          = 16;
   localparam int CLK_PERIOD_NS   = 8;
   // One wait state lasts one peripheral clock period
   localparam int PERIPHERAL_CLOCK_PERIOD_NS = 8;
   localparam int WAIT_STATE_CYCLES = (PERIPHERAL_CLOCK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Field encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] MUX_NONE   = 2'h0;
   localparam logic [1:0] MUX_PART   = 2'h1;
   localparam logic [1:0] MUX_FULL8  = 2'h2;
   localparam logic [1:0] MUX_FULL16 = 2'h3;
   localparam logic [1:0] STEP_NONE  = 2'h0;
   localparam logic [1:0] STEP_INC   = 2'h1;
   localparam logic [1:0] STEP_DEC   = 2'h2;
   localparam logic [1:0] CSF_NONE   = 2'h0;
   localparam logic [1:0] CSF_HIGH   = 2'h1;
   localparam logic [1:0] CSF_BOTH   = 2'h2;
   localparam logic [3:0] STROBE_WAIT_COUNT_NONE = 4'h0;

   // ----------------------------------------------------------------
   // Pin positions, phase counts and reset values
   // ----------------------------------------------------------------
   localparam int CS_HIGH_PIN  = 15;
   localparam int CS_LOW_PIN   = 14;
   localparam int LATCH_LO_PIN = 0;
   localparam int LATCH_HI_PIN = 1;
   localparam logic [3:0] ADDR_GAP_CYCLES = 4'h2;
   localparam logic [3:0] DEF_WR_HOLD     = 4'h1;
   localparam logic [3:0] DEF_RD_HOLD     = 4'h0;
   localparam logic [15:0] ADDR_RESET     = 16'h0000;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE, ST_LAT_LO, ST_GAP_LO, ST_LAT_HI, ST_GAP_HI, ST_SETUP, ST_STROBE, ST_HOLD
   } pmpm_state_e;

   typedef struct packed {
      logic        port_enable;
      logic        master_mode1;
      logic        wide_data_select;
      logic [1:0]  address_multiplex_select;
      logic [1:0]  address_step_select;
      logic [1:0]  setup_wait_count;
      logic [3:0]  strobe_wait_count;
      logic [1:0]  hold_wait_count;
      logic [1:0]  chip_select_function;
      logic        write_strobe_pin_enable;
      logic        read_strobe_pin_enable;
      logic [15:0] address_pin_enable;
      logic        read_strobe_polarity;
      logic        write_strobe_polarity;
      logic        chip_select_high_polarity;
      logic        chip_select_low_polarity;
      logic        latch_strobe_polarity;
   } pmpm_cfg_s;

   typedef struct packed {
      logic        write;
      logic [15:0] data;
   } pmpm_req_s;

endpackage

// ==== bench/pmpm_mem_model.sv ====
module pmpm_mem_model
   import pmpm_pkg::*;
(
   // Pins seen from the memory
   input  wire logic        clk_i,
   input  wire logic [15:0] address_pins_i,
   input  wire logic        read_strobe_i,
   input  wire logic        read_active_i,
   output logic      [15:0] data_pins_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] last_q;
   // Word follows the address while the read strobe is active; a released bus toggles
   assign data_pins_o = (read_strobe_i === read_active_i) ? ({2'h0, address_pins_i[13:0]} ^ 16'hC33C) : ~last_q;
   // Remember the last driven value so the idle bus never repeats it
   always_ff @(posedge clk_i) begin
      last_q <= data_pins_o;
   end
endmodule

// ==== bench/tb.sv ====
module tb;
   import pmpm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, addr_load_i, busy_o, req_valid_i, req_ready_o, rd_valid_o, rd_ready_i;
   logic read_strobe_o, read_strobe_oe_o, write_strobe_o, write_strobe_oe_o;
   logic [15:0] addr_load_data_i, address_register_o, rd_data_o, address_pins_o, address_pins_oe_o;
   logic [15:0] data_pins_i, data_pins_o, data_pins_oe_o, exp_a, wr_seen, lat_seen, q[$];
   pmpm_cfg_s cfg;
   pmpm_req_s req;
   logic [31:0] r;
   int miscompares, n_checks, cyc, wr_cnt, lat_cnt;
   pmpm_master_port dut (.clk_i(clk_i), .rst_i(rst_i), .cfg_i(cfg), .addr_load_i(addr_load_i),
      .addr_load_data_i(addr_load_data_i), .address_register_o(address_register_o), .busy_o(busy_o),
      .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req), .rd_valid_o(rd_valid_o),
      .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o), .address_pins_o(address_pins_o),
      .address_pins_oe_o(address_pins_oe_o), .data_pins_i(data_pins_i), .data_pins_o(data_pins_o),
      .data_pins_oe_o(data_pins_oe_o), .read_strobe_o(read_strobe_o), .read_strobe_oe_o(read_strobe_oe_o),
      .write_strobe_o(write_strobe_o), .write_strobe_oe_o(write_strobe_oe_o));
   pmpm_mem_model mem (.clk_i(clk_i), .address_pins_i(address_pins_o), .read_strobe_i(read_strobe_o),
      .read_active_i(cfg.read_strobe_polarity), .data_pins_o(data_pins_i));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (e !== g) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // One transfer: hold the request until taken, then wait for the sequencer to finish
   task automatic xfer(input logic wr, input logic [15:0] d);
      int n;
      @(negedge clk_i);
      wr_cnt = 0;
      lat_cnt = 0;
      req = '{write: wr, data: d};
      req_valid_i = 1'b1;
      n = 0;
      // Ready is looked at on the falling edge, where it has settled
      while (req_ready_o !== 1'b1 && n < 60) begin
         @(negedge clk_i);
         n++;
      end
      if (n == 60) begin
         miscompares++;
         $display("[FAIL] request taken expected 1 seen 0");
      end
      @(negedge clk_i);
      req_valid_i = 1'b0;
      chk("busy", 16'h1, {15'h0, busy_o});
      repeat (40) @(negedge clk_i);
      if (wr) chk("write data", d, wr_seen);
      if (wr) chk("strobe cycles", 16'(cfg.strobe_wait_count) + 16'h1, 16'(wr_cnt));
      case (cfg.address_step_select)
         STEP_INC: exp_a[13:0] = exp_a[13:0] + 14'h1;
         STEP_DEC: exp_a[13:0] = exp_a[13:0] - 14'h1;
         default: ;
      endcase
      chk("address", exp_a, address_register_o);
      chk("cs idle", {14'h0, ~cfg.chip_select_high_polarity, ~cfg.chip_select_low_polarity},
          {14'h0, address_pins_o[15:14]});
      chk("addr pins", exp_a & 16'h3FFC, address_pins_o & 16'h3FFC);
      chk("pins 1:0", cfg.address_multiplex_select == MUX_NONE ? exp_a & 16'h3 : 16'h3,
          address_pins_o & 16'h3);
      chk("pin enables", cfg.address_pin_enable, address_pins_oe_o);
   endtask
   // ----------------------------------------------------------------
   // Clock, timeout and monitors
   // ----------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // Strobe length and data seen on the pins, plus the ceiling on run time
   always @(posedge clk_i) begin
      cyc++;
      if (write_strobe_o === cfg.write_strobe_polarity && write_strobe_oe_o === 1'b1) begin
         wr_cnt++;
         wr_seen = data_pins_o & data_pins_oe_o;
      end
      // Address bytes as the latch strobes present them
      if (cfg.address_multiplex_select != MUX_NONE && address_pins_o[0] === cfg.latch_strobe_polarity) begin
         lat_cnt++;
         lat_seen[7:0] = data_pins_o[7:0];
      end
      if (cfg.address_multiplex_select != MUX_NONE && address_pins_o[1] === cfg.latch_strobe_polarity) begin
         lat_cnt++;
         lat_seen[15:8] = data_pins_o[7:0];
      end
      if (cyc == 20000) begin
         miscompares++;
         wrap_up();
      end
   end
   // Read words leave the buffer in order; compare each against the oldest note
   always @(posedge clk_i) begin
      if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1 && q.size() > 0) chk("read data", q.pop_front(), rd_data_o);
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      r = 32'h6049922e;
      cfg = '0;
      {req_valid_i, addr_load_i, rd_ready_i, req} = '0;
      addr_load_data_i = 16'h0000;
      rst_i = 1'b1;
      {cfg.port_enable, cfg.wide_data_select, cfg.write_strobe_pin_enable, cfg.read_strobe_pin_enable} = 4'hF;
      cfg.chip_select_function = CSF_BOTH;
      cfg.address_pin_enable = 16'hFFFF;
      repeat (16) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (2) @(negedge clk_i);
      r = lfsr(r);
      exp_a = r[15:0];
      addr_load_data_i = r[15:0];
      addr_load_i = 1'b1;
      @(negedge clk_i);
      addr_load_i = 1'b0;
      rd_ready_i = 1'b1;
      for (int i = 0; i < 12; i++) begin
         r = lfsr(r);
         {cfg.write_strobe_polarity, cfg.chip_select_high_polarity, cfg.chip_select_low_polarity} = r[2:0];
         cfg.address_step_select = 2'(i % 3);
         cfg.strobe_wait_count = 4'(i % 4);
         xfer(1'b1, r[31:16]);
      end
      $display("write tests done");
      cfg.strobe_wait_count = 4'h6;
      rd_ready_i = 1'b0;
      for (int i = 0; i < 2; i++) begin
         q.push_back({2'h0, exp_a[13:0]} ^ 16'hC33C);
         xfer(1'b0, 16'h0000);
      end
      chk("ready full", 16'h0, {15'h0, req_ready_o});
      rd_ready_i = 1'b1;
      repeat (6) @(negedge clk_i);
      chk("reads drained", 16'h0, 16'(q.size()));
      $display("read tests done");
      cfg.address_multiplex_select = MUX_FULL8;
      cfg.address_step_select = STEP_NONE;
      {cfg.setup_wait_count, cfg.hold_wait_count} = 4'h5;
      xfer(1'b1, r[15:0]);
      chk("latch cycles", 16'h4, 16'(lat_cnt));
      chk("mux address", exp_a & 16'h3FFF, lat_seen);
      $display("mux tests done");
      wrap_up();
   end
endmodule
